// ===== design/cal_limits_pkg.sv
// constants for the current and temperature calibration and limit block
package cal_limits_pkg;

   // ****************************************
   // geometry
   // ****************************************
   localparam int NUM_CHAN = 4;
   localparam int NUM_REG = 14;
   localparam int FIX_W = 48;
   localparam int FIX_FRAC = 16;
   localparam int DGAIN_FRAC = 14;

   typedef logic [15:0] word_t;
   typedef logic signed [47:0] fix_t;

   // ****************************************
   // command codes
   // ****************************************
   localparam logic [7:0] CMD_SENSE_GAIN = 8'h38;
   localparam logic [7:0] CMD_OC_FAULT = 8'h46;
   localparam logic [7:0] CMD_OC_WARN = 8'h4A;
   localparam logic [7:0] CMD_REV_CURRENT = 8'h4B;
   localparam logic [7:0] CMD_OT_FAULT = 8'h4F;
   localparam logic [7:0] CMD_OT_WARN = 8'h51;
   localparam logic [7:0] CMD_UT_WARN = 8'h52;
   localparam logic [7:0] CMD_UT_FAULT = 8'h53;
   localparam logic [7:0] CMD_SELF_HEAT = 8'hB8;
   localparam logic [7:0] CMD_TAU_INV = 8'hB9;
   localparam logic [7:0] CMD_THETA = 8'hBA;
   localparam logic [7:0] CMD_TEMPCO = 8'hF6;
   localparam logic [7:0] CMD_DIODE_GAIN = 8'hF8;
   localparam logic [7:0] CMD_DIODE_OFS = 8'hF9;

   // ****************************************
   // storage slots, one per command
   // ****************************************
   localparam logic [3:0] IDX_SENSE_GAIN = 4'h0;
   localparam logic [3:0] IDX_OC_FAULT = 4'h1;
   localparam logic [3:0] IDX_OC_WARN = 4'h2;
   localparam logic [3:0] IDX_REV_CURRENT = 4'h3;
   localparam logic [3:0] IDX_OT_FAULT = 4'h4;
   localparam logic [3:0] IDX_OT_WARN = 4'h5;
   localparam logic [3:0] IDX_UT_WARN = 4'h6;
   localparam logic [3:0] IDX_UT_FAULT = 4'h7;
   localparam logic [3:0] IDX_SELF_HEAT = 4'h8;
   localparam logic [3:0] IDX_TAU_INV = 4'h9;
   localparam logic [3:0] IDX_THETA = 4'hA;
   localparam logic [3:0] IDX_TEMPCO = 4'hB;
   localparam logic [3:0] IDX_DIODE_GAIN = 4'hC;
   localparam logic [3:0] IDX_DIODE_OFS = 4'hD;

   // ****************************************
   // values after reset, in slot order
   // ****************************************
   localparam word_t REG_RST [NUM_REG] = '{
      16'hBA00, 16'hD280, 16'hCA80, 16'hB400,
      16'hEA08, 16'hE3C0, 16'h8000, 16'hCD80,
      16'h0000, 16'h8000, 16'h8000, 16'h0000,
      16'h4000, 16'h8000};

   // ****************************************
   // fixed point constants, 16 fraction bits, except the integer divisor PPM_DIV
   // ****************************************
   localparam fix_t FIX_ONE = 48'sh0000_0001_0000;
   localparam fix_t CORR_MIN = 48'sh0000_0000_4000;
   localparam fix_t CORR_MAX = 48'sh0000_0004_0000;
   localparam fix_t GAIN_MIN = 48'sh0000_0000_028F;
   localparam fix_t GAIN_MAX = 48'sh0000_03E8_0000;
   localparam fix_t TEMP_REF = 48'sh0000_0019_0000;
   localparam fix_t KELVIN_OFS = 48'sh0000_0111_2666;
   localparam fix_t LSB_NEG = 48'shFFFF_FFFF_FFFF;
   localparam logic signed [63:0] PPM_DIV = 64'sh0000_0000_000F_4240;

endpackage : cal_limits_pkg

// ===== design/current_temp_calibration_limits.sv
// paged calibration and limit registers with current and temperature scaling
// Function
// - per channel sense gain word, milliohms, reset 1.0 milliohm
// - current reading is sense voltage over gain times correction
// - sense gain clamped to 0.01 through 1000 milliohm before use
// - readback returns the written word, never the clamped value
// - temperature correction clamped between 0.25 and 4.0
// - correction from tempco, temperature, self heating; thresholds limit*gain*corr
// - tempco word is signed 16 bit ppm per degree, reset zero
// - each channel uses its own diode temperature
// - no valid diode temperature: die temperature used, gain and offset ignored
// - overcurrent fault limit per channel, reset 10 A
// - overcurrent warning limit per channel, reset 5 A
// - reverse current limit per channel, reset -1 A, host keeps it negative
// - overcurrent fault limit used internally is never below zero
// - reverse current limit used internally is always below zero
// - overtemperature fault and warning limits, reset 65 and 60 degrees
// - undertemperature warning and fault limits, reset 0 and -5 degrees
// - temperature is kelvin times diode gain minus 273.15 plus offset
// - diode gain unsigned with weight 2^-14, reset 1.0
// - diode offset in linear eleven format degrees, reset zero
// - self heating rise is read only per channel
// - inverse thermal time constant per channel, reset 0.0
// - thermal resistance per channel, reset 0.0
`timescale 1ns/10ps
`default_nettype none

module current_temp_calibration_limits (
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // command port
   input wire logic [1:0] cmdPage,
   input wire logic [7:0] cmdCode,
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [15:0] cmdWrData,
   output logic [15:0] cmdRdData,
   output logic cmdRdValid,
   output logic cmdError,
   // self heating engine
   input wire logic shLoad,
   input wire logic [1:0] shChan,
   input wire logic [15:0] shWord,
   // measurement sample, 16 fraction bits
   input wire logic smpValid,
   input wire logic [1:0] smpChan,
   input wire logic signed [31:0] senseMv,
   input wire logic [31:0] diodeKelvin,
   input wire logic diodeOk,
   input wire logic signed [31:0] dieTemp,
   // results, 16 fraction bits; tauInvWord and thetaWord are raw register words
   output logic resValid,
   output logic [1:0] resChan,
   output logic signed [31:0] readCurrent,
   output logic signed [31:0] ocFaultMv,
   output logic signed [31:0] ocWarnMv,
   output logic signed [31:0] revCurrentMv,
   output logic signed [31:0] extTemp,
   output logic [15:0] tauInvWord,
   output logic [15:0] thetaWord
);

   // ****************************************
   // helpers
   // ****************************************
   // biased exponent e+16 is the exponent with its sign bit flipped
   function automatic cal_limits_pkg::fix_t l11ToFix(input logic [15:0] w);
      logic [4:0] sh;
      cal_limits_pkg::fix_t m;
      sh = {~w[15], w[14:11]};
      m = cal_limits_pkg::fix_t'(signed'(w[10:0]));
      return m <<< sh;
   endfunction : l11ToFix

   // results saturate instead of wrapping when they leave 32 bits
   function automatic logic signed [31:0] sat32(input cal_limits_pkg::fix_t v);
      if (v > 48'sh0000_7FFF_FFFF)
         return 32'sh7FFF_FFFF;
      else if (v < 48'shFFFF_8000_0000)
         return 32'sh8000_0000;
      else
         return v[31:0];
   endfunction : sat32

   // ****************************************
   // command decode
   // ****************************************
   logic cmdHit;
   logic [3:0] cmdIdx;

   always_comb
   begin
      cmdHit = 1'b1;
      cmdIdx = cal_limits_pkg::IDX_SENSE_GAIN;
      if (cmdCode == cal_limits_pkg::CMD_SENSE_GAIN)
         cmdIdx = cal_limits_pkg::IDX_SENSE_GAIN;
      else if (cmdCode == cal_limits_pkg::CMD_OC_FAULT)
         cmdIdx = cal_limits_pkg::IDX_OC_FAULT;
      else if (cmdCode == cal_limits_pkg::CMD_OC_WARN)
         cmdIdx = cal_limits_pkg::IDX_OC_WARN;
      else if (cmdCode == cal_limits_pkg::CMD_REV_CURRENT)
         cmdIdx = cal_limits_pkg::IDX_REV_CURRENT;
      else if (cmdCode == cal_limits_pkg::CMD_OT_FAULT)
         cmdIdx = cal_limits_pkg::IDX_OT_FAULT;
      else if (cmdCode == cal_limits_pkg::CMD_OT_WARN)
         cmdIdx = cal_limits_pkg::IDX_OT_WARN;
      else if (cmdCode == cal_limits_pkg::CMD_UT_WARN)
         cmdIdx = cal_limits_pkg::IDX_UT_WARN;
      else if (cmdCode == cal_limits_pkg::CMD_UT_FAULT)
         cmdIdx = cal_limits_pkg::IDX_UT_FAULT;
      else if (cmdCode == cal_limits_pkg::CMD_SELF_HEAT)
         cmdIdx = cal_limits_pkg::IDX_SELF_HEAT;
      else if (cmdCode == cal_limits_pkg::CMD_TAU_INV)
         cmdIdx = cal_limits_pkg::IDX_TAU_INV;
      else if (cmdCode == cal_limits_pkg::CMD_THETA)
         cmdIdx = cal_limits_pkg::IDX_THETA;
      else if (cmdCode == cal_limits_pkg::CMD_TEMPCO)
         cmdIdx = cal_limits_pkg::IDX_TEMPCO;
      else if (cmdCode == cal_limits_pkg::CMD_DIODE_GAIN)
         cmdIdx = cal_limits_pkg::IDX_DIODE_GAIN;
      else if (cmdCode == cal_limits_pkg::CMD_DIODE_OFS)
         cmdIdx = cal_limits_pkg::IDX_DIODE_OFS;
      else
         cmdHit = 1'b0;
   end

   wire logic isRo = (cmdIdx == cal_limits_pkg::IDX_SELF_HEAT);
   wire logic doWrite = ce && cmdWrite && cmdHit && !isRo;
   wire logic badCmd = (cmdWrite || cmdRead) && (!cmdHit || (cmdWrite && isRo));

   // ****************************************
   // register storage
   // ****************************************
   // raw words are kept as written; clamping happens only on the math path
   cal_limits_pkg::word_t regs_r [cal_limits_pkg::NUM_CHAN][cal_limits_pkg::NUM_REG];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int c = 0; c < cal_limits_pkg::NUM_CHAN; c++)
            for (int r = 0; r < cal_limits_pkg::NUM_REG; r++)
               regs_r[c][r] <= cal_limits_pkg::REG_RST[r];
      end
      else if (ce)
      begin
         if (doWrite)
            regs_r[cmdPage][cmdIdx] <= cmdWrData;
         if (shLoad)
            regs_r[shChan][cal_limits_pkg::IDX_SELF_HEAT] <= shWord;
      end
   end

   // ****************************************
   // readback
   // ****************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cmdRdData <= 16'h0000;
         cmdRdValid <= 1'b0;
         cmdError <= 1'b0;
      end
      else if (ce)
      begin
         cmdRdValid <= cmdRead;
         cmdError <= badCmd;
         if (cmdRead)
            cmdRdData <= cmdHit ? regs_r[cmdPage][cmdIdx] : 16'h0000;
      end
   end

   // ****************************************
   // temperature path
   // ****************************************
   wire cal_limits_pkg::word_t gainW = regs_r[smpChan][cal_limits_pkg::IDX_SENSE_GAIN];
   wire cal_limits_pkg::word_t tcW = regs_r[smpChan][cal_limits_pkg::IDX_TEMPCO];
   wire cal_limits_pkg::word_t dGainW = regs_r[smpChan][cal_limits_pkg::IDX_DIODE_GAIN];

   wire logic [47:0] diodeProd = diodeKelvin * dGainW;
   wire cal_limits_pkg::fix_t diodeScaled =
      cal_limits_pkg::fix_t'(diodeProd >> cal_limits_pkg::DGAIN_FRAC);
   wire cal_limits_pkg::fix_t ofsFix =
      l11ToFix(regs_r[smpChan][cal_limits_pkg::IDX_DIODE_OFS]);
   wire cal_limits_pkg::fix_t diodeTemp =
      diodeScaled - cal_limits_pkg::KELVIN_OFS + ofsFix;
   // a failed diode network falls back on the die, bypassing gain and offset
   wire cal_limits_pkg::fix_t tempFix =
      diodeOk ? diodeTemp : cal_limits_pkg::fix_t'(dieTemp);

   // ****************************************
   // temperature correction
   // ****************************************
   wire cal_limits_pkg::fix_t shFix =
      l11ToFix(regs_r[smpChan][cal_limits_pkg::IDX_SELF_HEAT]);
   wire cal_limits_pkg::fix_t deltaT = tempFix + shFix - cal_limits_pkg::TEMP_REF;
   wire logic signed [63:0] tcProd = signed'(tcW) * deltaT;
   wire logic signed [63:0] corrDelta = tcProd / cal_limits_pkg::PPM_DIV;
   wire cal_limits_pkg::fix_t corrRaw =
      cal_limits_pkg::FIX_ONE + cal_limits_pkg::fix_t'(corrDelta);
   wire cal_limits_pkg::fix_t corr =
      (corrRaw < cal_limits_pkg::CORR_MIN) ? cal_limits_pkg::CORR_MIN :
      (corrRaw > cal_limits_pkg::CORR_MAX) ? cal_limits_pkg::CORR_MAX :
      corrRaw;

   // ****************************************
   // effective sense gain
   // ****************************************
   wire cal_limits_pkg::fix_t gainFix = l11ToFix(gainW);
   wire cal_limits_pkg::fix_t gainClamp =
      (gainFix < cal_limits_pkg::GAIN_MIN) ? cal_limits_pkg::GAIN_MIN :
      (gainFix > cal_limits_pkg::GAIN_MAX) ? cal_limits_pkg::GAIN_MAX :
      gainFix;
   wire logic signed [95:0] gainProd = gainClamp * corr;
   // never zero: smallest gain times smallest correction stays positive
   wire cal_limits_pkg::fix_t gainEff =
      cal_limits_pkg::fix_t'(gainProd >>> cal_limits_pkg::FIX_FRAC);

   // ****************************************
   // limits and thresholds
   // ****************************************
   wire cal_limits_pkg::fix_t ocFaultFix =
      l11ToFix(regs_r[smpChan][cal_limits_pkg::IDX_OC_FAULT]);
   wire cal_limits_pkg::fix_t ocWarnFix =
      l11ToFix(regs_r[smpChan][cal_limits_pkg::IDX_OC_WARN]);
   wire cal_limits_pkg::fix_t revFix =
      l11ToFix(regs_r[smpChan][cal_limits_pkg::IDX_REV_CURRENT]);
   wire cal_limits_pkg::fix_t ocFaultUse =
      ocFaultFix[47] ? '0 : ocFaultFix;
   // a non-negative word is pulled to one lsb below zero
   wire cal_limits_pkg::fix_t revUse =
      revFix[47] ? revFix : cal_limits_pkg::LSB_NEG;

   wire logic signed [95:0] ocFaultProd = ocFaultUse * gainEff;
   wire logic signed [95:0] ocWarnProd = ocWarnFix * gainEff;
   wire logic signed [95:0] revProd = revUse * gainEff;

   // ****************************************
   // current reading
   // ****************************************
   wire cal_limits_pkg::fix_t senseShift =
      cal_limits_pkg::fix_t'(senseMv) <<< cal_limits_pkg::FIX_FRAC;
   wire cal_limits_pkg::fix_t currentFix = senseShift / gainEff;

   // ****************************************
   // result registers
   // ****************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         resValid <= 1'b0;
         resChan <= 2'h0;
         readCurrent <= 32'sh0000_0000;
         ocFaultMv <= 32'sh0000_0000;
         ocWarnMv <= 32'sh0000_0000;
         revCurrentMv <= 32'sh0000_0000;
         extTemp <= 32'sh0000_0000;
         tauInvWord <= 16'h0000;
         thetaWord <= 16'h0000;
      end
      else if (ce)
      begin
         resValid <= smpValid;
         if (smpValid)
         begin
            resChan <= smpChan;
            readCurrent <= sat32(currentFix);
            ocFaultMv <= sat32(cal_limits_pkg::fix_t'(ocFaultProd >>> 16));
            ocWarnMv <= sat32(cal_limits_pkg::fix_t'(ocWarnProd >>> 16));
            revCurrentMv <= sat32(cal_limits_pkg::fix_t'(revProd >>> 16));
            extTemp <= sat32(tempFix);
            tauInvWord <= regs_r[smpChan][cal_limits_pkg::IDX_TAU_INV];
            thetaWord <= regs_r[smpChan][cal_limits_pkg::IDX_THETA];
         end
      end
   end

endmodule : current_temp_calibration_limits

`default_nettype wire

// ===== verif/cal_limits_sva.sv
// assertion checker for the calibration and limit block
`timescale 1ns/10ps
`default_nettype none
module cal_limits_sva (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // command port
   input wire logic [1:0] cmdPage,
   input wire logic [7:0] cmdCode,
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [15:0] cmdWrData,
   input wire logic [15:0] cmdRdData,
   input wire logic cmdRdValid,
   input wire logic cmdError,
   // samples and results
   input wire logic smpValid,
   input wire logic [1:0] smpChan,
   input wire logic diodeOk,
   input wire logic signed [31:0] dieTemp,
   input wire logic resValid,
   input wire logic [1:0] resChan,
   input wire logic signed [31:0] ocFaultMv,
   input wire logic signed [31:0] revCurrentMv,
   input wire logic signed [31:0] extTemp
);
   wire logic known;
   wire logic wrOk;
   logic lastOk_r;
   logic [15:0] lastData_r;
   logic [9:0] lastKey_r;
   assign known = cmdCode inside {8'h38, 8'h46, 8'h4A, 8'h4B, 8'h4F, 8'h51, 8'h52, 8'h53,
      8'hB8, 8'hB9, 8'hBA, 8'hF6, 8'hF8, 8'hF9};
   assign wrOk = ce && cmdWrite && known && cmdCode != 8'hB8;
   // only the latest accepted write is tracked, enough to catch a clamped readback
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         lastOk_r <= 1'b0;
      else if (wrOk)
         lastOk_r <= 1'b1;
   end
   always_ff @(posedge clk)
   begin
      if (wrOk)
      begin
         lastData_r <= cmdWrData;
         lastKey_r <= {cmdPage, cmdCode};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_rd;
      ce && cmdRead;
   endsequence
   sequence s_rd_last;
      s_rd ##0 (lastOk_r && {cmdPage, cmdCode} == lastKey_r);
   endsequence
   a_read_valid_pulse: assert property (s_rd |=> cmdRdValid ##1 !cmdRdValid)
      else $error("read answer missing or too long");
   a_no_stray_valid: assert property (!(ce && cmdRead) |=> !cmdRdValid)
      else $error("read answer without a read");
   a_raw_readback: assert property (s_rd_last |=> cmdRdData == $past(lastData_r))
      else $error("readback differs from written word");
   a_selfheat_ro: assert property (ce && cmdWrite && cmdCode == 8'hB8 |=> cmdError)
      else $error("write to self heat word accepted");
   a_selfheat_read: assert property (s_rd ##0 cmdCode == 8'hB8 |=> !cmdError)
      else $error("self heat read refused");
   a_result_chan: assert property (ce && smpValid |=> resValid && resChan == $past(smpChan))
      else $error("result missing or wrong channel");
   a_oc_floor: assert property (resValid |-> ocFaultMv >= 0)
      else $error("overcurrent threshold below zero");
   a_rev_negative: assert property (resValid |-> revCurrentMv < 0)
      else $error("reverse threshold not negative");
   a_die_fallback: assert property (ce && smpValid && !diodeOk |=> extTemp == $past(dieTemp))
      else $error("die temperature not used");
endmodule : cal_limits_sva
bind current_temp_calibration_limits cal_limits_sva sva (.clk, .nrst, .ce, .cmdPage, .cmdCode,
   .cmdWrite, .cmdRead, .cmdWrData, .cmdRdData, .cmdRdValid, .cmdError, .smpValid, .smpChan,
   .diodeOk, .dieTemp, .resValid, .resChan, .ocFaultMv, .revCurrentMv, .extTemp);
`default_nettype wire

// ===== verif/pmbus_host.sv
// host model issuing word reads and writes on the command port
`timescale 1ns/10ps
`default_nettype none
module pmbus_host (
   // clock
   input wire logic clk,
   // command port
   output logic [1:0] cmdPage,
   output logic [7:0] cmdCode,
   output logic cmdWrite,
   output logic cmdRead,
   output logic [15:0] cmdWrData,
   input wire logic [15:0] cmdRdData,
   input wire logic cmdError
);
   initial
      {cmdPage, cmdCode, cmdWrite, cmdRead, cmdWrData} = '0;
   // data is inverted once released so a stale word can never pass as fresh
   task automatic wr(input logic [1:0] pg, input logic [7:0] code, input logic [15:0] w,
         output logic e);
      @(posedge clk);
      cmdPage <= pg;
      cmdCode <= code;
      cmdWrData <= w;
      cmdWrite <= 1'b1;
      @(posedge clk);
      cmdWrite <= 1'b0;
      cmdWrData <= ~w;
      #1;
      e = cmdError;
   endtask : wr
   task automatic rd(input logic [1:0] pg, input logic [7:0] code, output logic [15:0] w,
         output logic e);
      @(posedge clk);
      cmdPage <= pg;
      cmdCode <= code;
      cmdRead <= 1'b1;
      @(posedge clk);
      cmdRead <= 1'b0;
      #1;
      w = cmdRdData;
      e = cmdError;
   endtask : rd
endmodule : pmbus_host
`default_nettype wire

// ===== verif/tb_top.sv
// testbench for the calibration and limit block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, shLoad = 1'b0, smpValid = 1'b0, diodeOk = 1'b1;
   logic [1:0] shChan = 2'h0, smpChan = 2'h0;
   logic [15:0] shWord = 16'h0000, d;
   logic signed [31:0] senseMv = '0, dieTemp = '0;
   logic [31:0] diodeKelvin = '0;
   logic e;
   wire logic [1:0] cmdPage, resChan;
   wire logic [7:0] cmdCode;
   wire logic cmdWrite, cmdRead, cmdRdValid, cmdError, resValid;
   wire logic [15:0] cmdWrData, cmdRdData, tauInvWord, thetaWord;
   wire logic signed [31:0] readCurrent, ocFaultMv, ocWarnMv, revCurrentMv, extTemp;
   int bad_count = 0;
   int n_checks = 0;
   logic [7:0] codes [14] = '{8'h38, 8'h46, 8'h4A, 8'h4B, 8'h4F, 8'h51, 8'h52, 8'h53,
      8'hB8, 8'hB9, 8'hBA, 8'hF6, 8'hF8, 8'hF9};
   current_temp_calibration_limits uut (.clk, .nrst, .ce, .cmdPage, .cmdCode, .cmdWrite,
      .cmdRead, .cmdWrData, .cmdRdData, .cmdRdValid, .cmdError, .shLoad, .shChan, .shWord,
      .smpValid, .smpChan, .senseMv, .diodeKelvin, .diodeOk, .dieTemp, .resValid, .resChan,
      .readCurrent, .ocFaultMv, .ocWarnMv, .revCurrentMv, .extTemp, .tauInvWord, .thetaWord);
   pmbus_host host (.clk, .cmdPage, .cmdCode, .cmdWrite, .cmdRead, .cmdWrData, .cmdRdData,
      .cmdError);
   always #20 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      if (bad_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // one sample in, results checked in the cycle the answer stands
   task automatic smp(input logic [1:0] ch, input logic [31:0] mv, k, input logic ok,
         input logic [31:0] i, f, w, r, t);
      @(posedge clk);
      smpValid <= 1'b1;
      smpChan <= ch;
      senseMv <= mv;
      diodeKelvin <= k;
      diodeOk <= ok;
      @(posedge clk);
      smpValid <= 1'b0;
      #1;
      chk({resValid, resChan}, {1'b1, ch});
      chk(readCurrent, i);
      chk(ocFaultMv, f);
      chk(ocWarnMv, w);
      chk(revCurrentMv, r);
      chk(extTemp, t);
   endtask : smp
   task automatic t_defaults;
      for (int i = 0; i < 14; i++)
      begin
         host.rd(2'(i % 4), codes[i], d, e);
         chk(d, cal_limits_pkg::REG_RST[i]);
      end
   endtask : t_defaults
   task automatic t_clamps;
      host.wr(2'h2, 8'h38, 16'h0BE8, e); // 2000 mohm, above the clamp
      host.wr(2'h2, 8'h46, 16'hB400, e); // -1 A, host error tolerated internally
      host.wr(2'h2, 8'h4B, 16'hBC00, e); // -2 A, host keeps it negative
      host.rd(2'h2, 8'h38, d, e);
      chk(d, 16'h0BE8);
      host.rd(2'h2, 8'h46, d, e);
      chk(d, 16'hB400);
      smp(2'h2, 32'h03E8_0000, 32'h012A_2666, 1'b1, 32'h0001_0000, 32'h0000_0000,
         32'h1388_0000, 32'hF830_0000, 32'h0019_0000);
   endtask : t_clamps
   task automatic t_tempco;
      host.wr(2'h1, 8'hF6, 16'h7FFF, e);
      smp(2'h1, 32'h0008_0000, 32'h01F2_2666, 1'b1, 32'h0002_0000, 32'h0028_0000,
         32'h0014_0000, 32'hFFFC_0000, 32'h00E1_0000);
      smp(2'h0, 32'h0008_0000, 32'h01F2_2666, 1'b1, 32'h0008_0000, 32'h000A_0000,
         32'h0005_0000, 32'hFFFF_0000, 32'h00E1_0000);
      host.wr(2'h1, 8'hF6, 16'h8000, e);
      smp(2'h1, 32'h0001_0000, 32'h01F2_2666, 1'b1, 32'h0004_0000, 32'h0002_8000,
         32'h0001_4000, 32'hFFFF_C000, 32'h00E1_0000);
      host.wr(2'h1, 8'hF6, 16'h0F3C, e);
      smp(2'h1, 32'h0001_63D7, 32'h018E_2666, 1'b1, 32'h0001_0000, 32'h000D_E666,
         32'h0006_F333, 32'hFFFE_9C29, 32'h007D_0000);
   endtask : t_tempco
   task automatic t_diode;
      host.wr(2'h3, 8'hF8, 16'h2000, e);
      host.wr(2'h3, 8'hF9, 16'h0002, e);
      dieTemp <= 32'h0030_0000;
      smp(2'h3, 32'h0000_0000, 32'h0258_0000, 1'b1, 32'h0000_0000, 32'h000A_0000,
         32'h0005_0000, 32'hFFFF_0000, 32'h001C_D99A);
      smp(2'h3, 32'h0000_0000, 32'h0258_0000, 1'b0, 32'h0000_0000, 32'h000A_0000,
         32'h0005_0000, 32'hFFFF_0000, 32'h0030_0000);
      chk(tauInvWord, 16'h8000);
      chk(thetaWord, 16'h8000);
   endtask : t_diode
   task automatic t_selfheat;
      @(posedge clk);
      shLoad <= 1'b1;
      shChan <= 2'h3;
      shWord <= 16'h1234;
      @(posedge clk);
      shLoad <= 1'b0;
      host.wr(2'h3, 8'hB8, 16'h0055, e);
      chk(e, 1'b1);
      host.rd(2'h3, 8'hB8, d, e);
      chk({e, d}, 17'h0_1234);
      chk(cmdRdValid, 1'b1);
      host.rd(2'h0, 8'h00, d, e);
      chk({e, d}, 17'h1_0000);
   endtask : t_selfheat
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_defaults();
      t_clamps();
      t_tempco();
      t_diode();
      t_selfheat();
      wrap_up();
   end
   // the sequence needs under a hundred cycles; 5000 leaves ample margin
   initial
   begin
      #200000;
      bad_count++;
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
